// >>> common/rsr_pkg.sv
// package: constants for the reset source recorder
package rsr_pkg;
  // register addresses on the cpu data bus
  localparam logic [15:0] ADDR_RESET_CAUSE_FLAGS    = 16'hffac;
  localparam logic [15:0] ADDR_LOW_VOLTAGE_CONTROL  = 16'hffbe;
  localparam logic [15:0] ADDR_LOW_VOLTAGE_LEVEL    = 16'hffbf;
  localparam logic [15:0] ADDR_INTERRUPT_REQUEST    = 16'hffe0;
  localparam logic [15:0] ADDR_INTERRUPT_MASK       = 16'hffe4;
  localparam logic [15:0] ADDR_INTERRUPT_PRIORITY   = 16'hffe8;
  localparam logic [15:0] ADDR_RISING_EDGE_ENABLE   = 16'hff48;
  localparam logic [15:0] ADDR_FALLING_EDGE_ENABLE  = 16'hff49;

  // reset_cause_flags field positions
  localparam int unsigned WATCHDOG_FLAG_BIT    = 4;
  localparam int unsigned LOW_VOLTAGE_FLAG_BIT = 0;

  // reset values
  localparam logic [7:0] RESET_CAUSE_FLAGS_RESET = 8'h00;
  localparam logic [7:0] LOW_VOLTAGE_REGS_RESET  = 8'h00;
  localparam logic [7:0] INTERRUPT_REQUEST_RESET = 8'h00;
  localparam logic [7:0] INTERRUPT_MASK_RESET    = 8'hff;
  localparam logic [7:0] INTERRUPT_PRIO_RESET    = 8'hff;
  localparam logic [7:0] EDGE_ENABLE_RESET       = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE     = 8'h00;

  // oscillation-stabilization wait after internal reset release
  localparam int unsigned STABILIZE_CYCLES = 16;

  function automatic logic rsr_addr_hit(input logic [15:0] addr,
                                        input logic [15:0] target);
    rsr_addr_hit = (addr == target);
  endfunction : rsr_addr_hit
endpackage : rsr_pkg

// >>> rtl/rsr_low_voltage_regs.sv
// low-voltage detector control and level-select registers
module rsr_low_voltage_regs
  import rsr_pkg::*;
(
  input  wire logic       i_clk,          // system clock
  input  wire logic       i_reset,        // async power-on-clear reset
  input  wire logic       i_ce,           // clock enable
  input  wire logic       i_clear,        // pin, poc or watchdog reset
  input  wire logic       i_wr_en,        // cpu write strobe
  input  wire logic [15:0] i_addr,        // cpu address
  input  wire logic [7:0] i_wr_data,      // cpu write data
  output logic      [7:0] o_detect_control, // control register
  output logic      [7:0] o_level_select    // level select register
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] level;
  } rsr_lv_state_t;

  rsr_lv_state_t state_ff;
  rsr_lv_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (i_clear) begin
      nxt_state.ctrl  = LOW_VOLTAGE_REGS_RESET;
      nxt_state.level = LOW_VOLTAGE_REGS_RESET;
    end else if (i_wr_en) begin
      if (rsr_addr_hit(i_addr, ADDR_LOW_VOLTAGE_CONTROL)) begin
        nxt_state.ctrl = i_wr_data;
      end
      if (rsr_addr_hit(i_addr, ADDR_LOW_VOLTAGE_LEVEL)) begin
        nxt_state.level = i_wr_data;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= '{ctrl: LOW_VOLTAGE_REGS_RESET,
                    level: LOW_VOLTAGE_REGS_RESET};
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  assign o_detect_control = state_ff.ctrl;
  assign o_level_select   = state_ff.level;
endmodule : rsr_low_voltage_regs

// >>> rtl/rsr_reset_source_recorder.sv
// reset source recorder: combines reset sources and keeps cause flags
// Summary of operation
// - the watchdog flag is set by a watchdog reset, cleared by pin or power-on-clear reset, kept on a low-voltage reset.
// - the low-voltage flag is set by a low-voltage reset, cleared by pin or power-on-clear reset, kept on a watchdog reset.
// - reading the flag register returns the flags and then clears every flag not set again by a reset request in the same cycle.
// - the flag register is read-only with watchdog at bit 4, low-voltage at bit 0, others zero.
// - low-voltage control and level registers clear on pin, power-on-clear or watchdog reset and hold on low-voltage reset.
// - the program counter is flagged invalid during reset and the stabilization wait, and valid once the wait has counted down.
// - reset loads interrupt request 00, mask ff, priority ff and both edge enables 00.
// - the threshold option picks the power-up release level, while falling below the low level always reasserts.
// - any power-on-clear reset clears the entire flag register.
module rsr_reset_source_recorder
  import rsr_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = STABILIZE_CYCLES
) (
  input  wire logic        i_clk,               // system clock, 200 MHz
  input  wire logic        i_reset,             // power-on-clear core reset
  input  wire logic        i_ce,                // clock enable
  input  wire logic        i_reset_pin_n,       // external reset pin
  input  wire logic        i_watchdog_req,      // watchdog reset request
  input  wire logic        i_low_voltage_req,   // detector reset request
  input  wire logic        i_vdd_above_low,     // comparator, low level
  input  wire logic        i_vdd_above_high,    // comparator, high level
  input  wire logic        i_power_clear_threshold_option, // option byte
  input  wire logic        i_rd_en,             // cpu read strobe
  input  wire logic        i_wr_en,             // cpu write strobe
  input  wire logic [15:0] i_addr,              // cpu address
  input  wire logic [7:0]  i_wr_data,           // cpu write data
  output logic      [7:0]  o_rd_data,           // cpu read data
  output logic             o_internal_reset,    // combined reset
  output logic             o_pc_invalid,        // pc undefined
  output logic      [7:0]  o_low_voltage_detect_control, // lv control
  output logic      [7:0]  o_low_voltage_level_select,   // lv level
  output logic      [7:0]  o_interrupt_request_flags,    // request
  output logic      [7:0]  o_interrupt_mask_flags,       // mask
  output logic      [7:0]  o_interrupt_priority_flags,   // priority
  output logic      [7:0]  o_rising_edge_enable,         // edge enable
  output logic      [7:0]  o_falling_edge_enable         // edge enable
);
  localparam logic [15:0] STAB_LOAD = 16'(STAB_CYCLES);

  typedef struct packed {
    logic        pin_s1;
    logic        pin_s2;
    logic        lo_s1;
    logic        lo_s2;
    logic        hi_s1;
    logic        hi_s2;
    logic        power_on_clear;
    logic        option;
    logic        watchdog_reset_flag;
    logic        low_voltage_reset_flag;
    logic        rst_out;
    logic        pc_inv;
    logic [15:0] stab_cnt;
    logic [7:0]  rd_data;
    logic [7:0]  irq_req;
    logic [7:0]  irq_mask;
    logic [7:0]  irq_prio;
    logic [7:0]  edge_rise;
    logic [7:0]  edge_fall;
  } rsr_state_t;

  // pin idle high, supply assumed low, poc asserted at power-up
  localparam rsr_state_t STATE_RESET = '{
    pin_s1: 1'b1, pin_s2: 1'b1, lo_s1: 1'b0, lo_s2: 1'b0,
    hi_s1: 1'b0, hi_s2: 1'b0, power_on_clear: 1'b1, option: 1'b0,
    watchdog_reset_flag: 1'b0, low_voltage_reset_flag: 1'b0,
    rst_out: 1'b1, pc_inv: 1'b1, stab_cnt: STAB_LOAD,
    rd_data: UNMAPPED_READ_VALUE, irq_req: INTERRUPT_REQUEST_RESET,
    irq_mask: INTERRUPT_MASK_RESET, irq_prio: INTERRUPT_PRIO_RESET,
    edge_rise: EDGE_ENABLE_RESET, edge_fall: EDGE_ENABLE_RESET};

  rsr_state_t state_ff;
  rsr_state_t nxt_state;

  logic       pin_active;
  logic       clear_all;
  logic       flag_read;
  logic [7:0] flags_now;
  logic [7:0] lv_ctrl;
  logic [7:0] lv_level;

  assign pin_active = ~state_ff.pin_s2;
  assign clear_all  = pin_active | state_ff.power_on_clear;
  assign flag_read  = i_rd_en & rsr_addr_hit(i_addr, ADDR_RESET_CAUSE_FLAGS);

  always_comb begin
    flags_now = RESET_CAUSE_FLAGS_RESET;
    flags_now[WATCHDOG_FLAG_BIT]    = state_ff.watchdog_reset_flag;
    flags_now[LOW_VOLTAGE_FLAG_BIT] = state_ff.low_voltage_reset_flag;
  end

  rsr_low_voltage_regs u_lv_regs (
    .i_clk            (i_clk),
    .i_reset          (i_reset),
    .i_ce             (i_ce),
    .i_clear          (clear_all | i_watchdog_req),
    .i_wr_en          (i_wr_en),
    .i_addr           (i_addr),
    .i_wr_data        (i_wr_data),
    .o_detect_control (lv_ctrl),
    .o_level_select   (lv_level)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_state.pin_s1 = i_reset_pin_n;
    nxt_state.pin_s2 = state_ff.pin_s1;
    nxt_state.lo_s1  = i_vdd_above_low;
    nxt_state.lo_s2  = state_ff.lo_s1;
    nxt_state.hi_s1  = i_vdd_above_high;
    nxt_state.hi_s2  = state_ff.hi_s1;

    // release threshold by option, reassert below low level
    if (state_ff.power_on_clear) begin
      nxt_state.option = i_power_clear_threshold_option;
    end
    if (!state_ff.lo_s2) begin
      nxt_state.power_on_clear = 1'b1;
    end else if (state_ff.power_on_clear) begin
      nxt_state.power_on_clear = state_ff.option ? ~state_ff.hi_s2 : 1'b0;
    end

    // power-on-clear and pin wipe both flags
    if (clear_all) begin
      nxt_state.watchdog_reset_flag    = 1'b0;
      nxt_state.low_voltage_reset_flag = 1'b0;
    end else begin
      // watchdog flag; a set in the read cycle wins over the clear
      if (i_watchdog_req) begin
        nxt_state.watchdog_reset_flag = 1'b1;
      end else if (flag_read) begin
        nxt_state.watchdog_reset_flag = 1'b0;
      end
      if (i_low_voltage_req) begin
        nxt_state.low_voltage_reset_flag = 1'b1;
      end else if (flag_read) begin
        nxt_state.low_voltage_reset_flag = 1'b0;
      end
    end

    nxt_state.rst_out = clear_all | i_watchdog_req | i_low_voltage_req;

    // pc invalid through reset and stabilization wait
    if (state_ff.rst_out) begin
      nxt_state.stab_cnt = STAB_LOAD;
    end else if (state_ff.stab_cnt != 16'h0000) begin
      nxt_state.stab_cnt = state_ff.stab_cnt - 16'h0001;
    end
    nxt_state.pc_inv = nxt_state.rst_out | (nxt_state.stab_cnt != 16'h0000);

    // interrupt registers loaded while reset stands
    if (state_ff.rst_out) begin
      nxt_state.irq_req   = INTERRUPT_REQUEST_RESET;
      nxt_state.irq_mask  = INTERRUPT_MASK_RESET;
      nxt_state.irq_prio  = INTERRUPT_PRIO_RESET;
      nxt_state.edge_rise = EDGE_ENABLE_RESET;
      nxt_state.edge_fall = EDGE_ENABLE_RESET;
    end else if (i_wr_en) begin
      if (rsr_addr_hit(i_addr, ADDR_INTERRUPT_REQUEST))
        nxt_state.irq_req = i_wr_data;
      if (rsr_addr_hit(i_addr, ADDR_INTERRUPT_MASK))
        nxt_state.irq_mask = i_wr_data;
      if (rsr_addr_hit(i_addr, ADDR_INTERRUPT_PRIORITY))
        nxt_state.irq_prio = i_wr_data;
      if (rsr_addr_hit(i_addr, ADDR_RISING_EDGE_ENABLE))
        nxt_state.edge_rise = i_wr_data;
      if (rsr_addr_hit(i_addr, ADDR_FALLING_EDGE_ENABLE))
        nxt_state.edge_fall = i_wr_data;
    end

    // read data holds between reads; unmapped reads return zero
    if (i_rd_en) begin
      unique case (i_addr)
        ADDR_RESET_CAUSE_FLAGS:   nxt_state.rd_data = flags_now;
        ADDR_LOW_VOLTAGE_CONTROL: nxt_state.rd_data = lv_ctrl;
        ADDR_LOW_VOLTAGE_LEVEL:   nxt_state.rd_data = lv_level;
        ADDR_INTERRUPT_REQUEST:   nxt_state.rd_data = state_ff.irq_req;
        ADDR_INTERRUPT_MASK:      nxt_state.rd_data = state_ff.irq_mask;
        ADDR_INTERRUPT_PRIORITY:  nxt_state.rd_data = state_ff.irq_prio;
        ADDR_RISING_EDGE_ENABLE:  nxt_state.rd_data = state_ff.edge_rise;
        ADDR_FALLING_EDGE_ENABLE: nxt_state.rd_data = state_ff.edge_fall;
        default:                  nxt_state.rd_data = UNMAPPED_READ_VALUE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= STATE_RESET;
    end else if (i_ce) begin
      state_ff <= nxt_state;
    end
  end

  assign o_rd_data                    = state_ff.rd_data;
  assign o_internal_reset             = state_ff.rst_out;
  assign o_pc_invalid                 = state_ff.pc_inv;
  assign o_low_voltage_detect_control = lv_ctrl;
  assign o_low_voltage_level_select   = lv_level;
  assign o_interrupt_request_flags    = state_ff.irq_req;
  assign o_interrupt_mask_flags       = state_ff.irq_mask;
  assign o_interrupt_priority_flags   = state_ff.irq_prio;
  assign o_rising_edge_enable         = state_ff.edge_rise;
  assign o_falling_edge_enable        = state_ff.edge_fall;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_wdt_flag_set: assert property (
    i_ce && i_watchdog_req && !clear_all |=> state_ff.watchdog_reset_flag)
    else $error("watchdog flag not set");
  a_lvi_flag_held: assert property (
    i_ce && i_watchdog_req && !i_low_voltage_req && !clear_all
      && !flag_read |=> $stable(state_ff.low_voltage_reset_flag))
    else $error("low-voltage flag disturbed by watchdog");
  a_read_clears: assert property (
    i_ce && flag_read && !clear_all && !i_watchdog_req
      && !i_low_voltage_req
      |=> o_rd_data == $past(flags_now) && flags_now == 8'h00)
    else $error("flag read did not return then clear");
  a_reserved_zero: assert property (
    i_ce && flag_read |=> (o_rd_data & 8'hee) == 8'h00)
    else $error("reserved flag bit reads nonzero");
  a_lv_clear: assert property (
    i_ce && (clear_all || i_watchdog_req)
      |=> lv_ctrl == 8'h00 && lv_level == 8'h00)
    else $error("low-voltage registers not cleared");
  a_pc_invalid: assert property (
    i_ce && state_ff.rst_out ##1 i_ce && !state_ff.rst_out
      |-> o_pc_invalid)
    else $error("pc valid before stabilization");
  a_irq_defaults: assert property (
    i_ce && state_ff.rst_out |=> o_interrupt_mask_flags == 8'hff
      && o_interrupt_priority_flags == 8'hff
      && o_interrupt_request_flags == 8'h00)
    else $error("interrupt reset values wrong");
  a_poc_reassert: assert property (
    i_ce && !state_ff.lo_s2 |=> state_ff.power_on_clear)
    else $error("power-on-clear not reasserted");
  a_poc_wipes: assert property (
    i_ce && state_ff.power_on_clear |=> flags_now == 8'h00)
    else $error("flags survive power-on-clear");
  a_reset_out: assert property (
    i_ce && (clear_all || i_watchdog_req || i_low_voltage_req)
      |=> o_internal_reset)
    else $error("internal reset not asserted");

  c_watchdog_reset: cover property (
    i_ce && i_watchdog_req && !clear_all ##1 i_ce && flag_read);
  c_low_voltage_reset: cover property (
    i_ce && i_low_voltage_req && !clear_all);
  c_pin_reset: cover property (i_ce && pin_active ##1 !pin_active);
endmodule : rsr_reset_source_recorder

// >>> testbench/rsr_source_model.sv
// behavioural model of the reset sources and supply comparators
module rsr_source_model (
  input  wire logic       i_clk,              // system clock
  input  wire logic [3:0] i_src,              // pin, watchdog, detector, drop
  input  wire logic       i_high_ok,          // supply above upper level
  output logic            o_reset_pin_n,      // external reset pin
  output logic            o_watchdog_req,     // watchdog request
  output logic            o_low_voltage_req,  // detector request
  output logic            o_vdd_above_low,    // lower comparator
  output logic            o_vdd_above_high    // upper comparator
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_reset_pin_n     = 1'b1;
    o_watchdog_req    = 1'b0;
    o_low_voltage_req = 1'b0;
    o_vdd_above_low   = 1'b1;
    o_vdd_above_high  = 1'b1;
  end
  // updates land after the edge, so the design sees them one edge later
  always @(posedge i_clk) begin
    o_reset_pin_n     <= ~i_src[0];
    o_watchdog_req    <= i_src[1];
    o_low_voltage_req <= i_src[2];
    // a supply drop pulls both comparators low
    o_vdd_above_low   <= ~i_src[3];
    o_vdd_above_high  <= ~i_src[3] & i_high_ok;
  end
endmodule : rsr_source_model

// >>> testbench/test_reset_source_recorder.sv
// self-checking bench for the reset source recorder
module test_reset_source_recorder;
  timeunit 1ns;
  timeprecision 100ps;
  import rsr_pkg::*;
  typedef struct packed {
    logic [3:0] src;
    logic       rd;
    logic [7:0] flags;
  } rsr_row_t;
  // src mask: 1 pin, 2 watchdog, 4 detector, 8 supply drop
  localparam rsr_row_t ROWS [12] = '{
    '{4'h2, 1'b1, 8'h10}, '{4'h0, 1'b1, 8'h00}, '{4'h4, 1'b0, 8'h00},
    '{4'h2, 1'b1, 8'h11}, '{4'h4, 1'b0, 8'h00}, '{4'h1, 1'b1, 8'h00},
    '{4'h2, 1'b0, 8'h00}, '{4'h4, 1'b1, 8'h11}, '{4'h2, 1'b0, 8'h00},
    '{4'h8, 1'b1, 8'h00}, '{4'h2, 1'b0, 8'h00}, '{4'h3, 1'b1, 8'h00}};
  logic       clk = 1'b0, rst = 1'b1, high_ok = 1'b1, opt = 1'b0;
  logic       rd_en = 1'b0, wr_en = 1'b0;
  logic [3:0] src = 4'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, v;
  logic       pin_n, wd, lv, above_low, above_high, int_rst, pc_inv;
  logic [7:0] rd_data, lv_ctl, lv_lvl, irq_req, irq_mask, irq_prio;
  logic [7:0] rise_en, fall_en;
  int         mismatches = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  rsr_source_model model (.i_clk(clk), .i_src(src), .i_high_ok(high_ok),
    .o_reset_pin_n(pin_n), .o_watchdog_req(wd), .o_low_voltage_req(lv),
    .o_vdd_above_low(above_low), .o_vdd_above_high(above_high));
  rsr_reset_source_recorder #(.STAB_CYCLES(2)) uut (.i_clk(clk),
    .i_reset(rst), .i_ce(1'b1), .i_reset_pin_n(pin_n),
    .i_watchdog_req(wd), .i_low_voltage_req(lv),
    .i_vdd_above_low(above_low), .i_vdd_above_high(above_high),
    .i_power_clear_threshold_option(opt), .i_rd_en(rd_en),
    .i_wr_en(wr_en), .i_addr(addr), .i_wr_data(wdata),
    .o_rd_data(rd_data), .o_internal_reset(int_rst),
    .o_pc_invalid(pc_inv), .o_low_voltage_detect_control(lv_ctl),
    .o_low_voltage_level_select(lv_lvl),
    .o_interrupt_request_flags(irq_req), .o_interrupt_mask_flags(irq_mask),
    .o_interrupt_priority_flags(irq_prio), .o_rising_edge_enable(rise_en),
    .o_falling_edge_enable(fall_en));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr
  // the flag register is only ever read as a whole byte
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr  = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask : rd
  task automatic wait_release();
    int k;
    for (k = 0; k < 200; k++) begin
      @(negedge clk);
      if (int_rst === 1'b0 && pc_inv === 1'b0) break;
    end
    if (k == 200) begin
      mismatches++;
      $display("[ERR] release expected 0 seen 1");
      close_out();
    end
  endtask : wait_release
  task automatic pulse(input logic [3:0] s);
    @(negedge clk);
    src = s;
    repeat (6) @(negedge clk);
    check("internal reset", 8'h01, {7'h0, int_rst});
    check("pc invalid", 8'h01, {7'h0, pc_inv});
    src = 4'h0;
    wait_release();
  endtask : pulse
  initial begin
    repeat (3) @(negedge clk);
    check("pc invalid in reset", 8'h01, {7'h0, pc_inv});
    rst = 1'b0;
    wait_release();
    check("request", INTERRUPT_REQUEST_RESET, irq_req);
    check("mask", 8'hff, irq_mask);
    check("priority", 8'hff, irq_prio);
    check("rising", 8'h00, rise_en);
    check("falling", 8'h00, fall_en);
    check("lv control", 8'h00, lv_ctl);
    check("lv level", 8'h00, lv_lvl);
    rd(ADDR_RESET_CAUSE_FLAGS, v);
    check("flags at reset", 8'h00, v);
    rd(16'h0000, v);
    check("unmapped", UNMAPPED_READ_VALUE, v);
    foreach (ROWS[i]) begin
      wr(ADDR_LOW_VOLTAGE_CONTROL, 8'h3c);
      wr(ADDR_LOW_VOLTAGE_LEVEL, 8'hc3);
      wr(ADDR_INTERRUPT_MASK, 8'h0f);
      if (ROWS[i].src != 4'h0) pulse(ROWS[i].src);
      // detector-only or no reset keeps the detector settings
      v = ((ROWS[i].src & 4'hb) == 4'h0) ? 8'h3c : 8'h00;
      check("lv control", v, lv_ctl);
      check("lv level", v & 8'hc3 | {8{v[2]}} & 8'hc3, lv_lvl);
      v = (ROWS[i].src != 4'h0) ? 8'hff : 8'h0f;
      check("mask", v, irq_mask);
      if (ROWS[i].rd) begin
        rd(ADDR_RESET_CAUSE_FLAGS, v);
        check("flags", ROWS[i].flags, v);
      end
    end
    // a write landing in the last reset cycle must not survive it
    @(negedge clk);
    src = 4'h2;
    repeat (6) @(negedge clk);
    src = 4'h0;
    wr(ADDR_INTERRUPT_MASK, 8'h00);
    wait_release();
    check("mask after write", 8'hff, irq_mask);
    wr(ADDR_RESET_CAUSE_FLAGS, 8'hff);
    rd(ADDR_RESET_CAUSE_FLAGS, v);
    check("flags read only", 8'h10, v);
    rd(ADDR_RESET_CAUSE_FLAGS, v);
    check("flags cleared", 8'h00, v);
    wr(ADDR_LOW_VOLTAGE_LEVEL, 8'h5a);
    rd(ADDR_LOW_VOLTAGE_LEVEL, v);
    check("lv level read", 8'h5a, v);
    rd(ADDR_INTERRUPT_PRIORITY, v);
    check("priority read", INTERRUPT_PRIO_RESET, v);
    // upper threshold mode: release waits for the upper comparator
    opt     = 1'b1;
    high_ok = 1'b0;
    @(negedge clk);
    src = 4'h8;
    repeat (6) @(negedge clk);
    src = 4'h0;
    repeat (10) @(negedge clk);
    check("upper hold", 8'h01, {7'h0, int_rst});
    high_ok = 1'b1;
    wait_release();
    opt     = 1'b0;
    high_ok = 1'b0;
    pulse(4'h8);
    high_ok = 1'b1;
    close_out();
  end
endmodule : test_reset_source_recorder
